// ---- hdl/rtcp_post_slot.sv ----
// rtcp_post_slot: one posted-write slot for a strobe duration register.
// assumes the writer only strobes wr while pending is low.
`timescale 1ns/100ps
`default_nettype none
module rtcp_post_slot #(
    parameter int W = 16,
    parameter logic [15:0] RST = 16'h0000
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // posting side
    input wire logic wr,
    input wire logic [W-1:0] wdata,
    input wire logic tick,
    // results
    output logic pending,
    output logic [W-1:0] value
);
    logic [W-1:0] buf_q;
    logic pend_q;
    logic [W-1:0] val_q;

    // a write parks in the buffer; the next prescaled tick commits it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_q <= 1'b0;
            buf_q <= '0;
            val_q <= RST;
        end else if (wr && !pend_q) begin
            pend_q <= 1'b1;
            buf_q <= wdata;
        end else if (pend_q && tick) begin
            pend_q <= 1'b0;
            val_q <= buf_q;
        end
    end

    assign pending = pend_q;
    assign value = val_q;
endmodule : rtcp_post_slot
`default_nettype wire

// ---- hdl/rtcp_top.sv ----
// rtcp_top: apb register file for the rtc count trim and posted
// strobe-duration writes, with the prescaler and count it trims.
// assumes a single pclk and an apb master keeping apb3 signalling.
// posted writes commit on the next prescale tick, so while the
// counter is stopped they stay pending and refuse further writes.
// every output comes straight from a flop.
//
// How it works
// - status bit 4 shows a pending channel 1 high-duration write
// - status bit 2 shows a pending channel 3 low-duration write
// - status bit 1 shows a pending channel 2 low-duration write
// - status bit 0 shows a pending channel 1 low-duration write
// - a write to a duration register still pending is refused
// - trim register holds trim amount and interval for count adjust
// - trim acts only with trim enable and counter enable both set
// - exponent in bits 9:6; interval is 2^(exp + 0..3)
// - exponent range 2 to 14, default 14, else treated as 14
// - interval select in bits 5:4 picks exponent offset 0 to 3
`timescale 1ns/100ps
`default_nettype none
module rtcp_top #(
    parameter int PRESCALE = rtcp_pkg::PRESCALE_CYC
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // rtc results
    output logic [31:0] rtc_count,
    output logic [15:0] strobe1_low_duration,
    output logic [15:0] strobe2_low_duration,
    output logic [15:0] strobe3_low_duration,
    output logic [15:0] strobe1_high_duration
);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // software-visible configuration
    logic [1:0] ctrl_q;
    logic [9:0] trm_q;

    // rtc count and the stall left by a subtracting trim
    logic [31:0] count_q;
    logic [31:0] count_d;
    logic [2:0] stall_q;
    logic [2:0] stall_d;

    // prescaler divider and its one-cycle tick
    logic [15:0] div_q;
    logic tick_q;

    // apb answer, flopped so no input reaches an output directly
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic pready_q;
    logic pslverr_q;
    logic err_d;

    // copies of the committed durations
    logic [15:0] dur1l_q;
    logic [15:0] dur2l_q;
    logic [15:0] dur3l_q;
    logic [15:0] dur1h_q;

    // ------------------------------------------------------------
    // apb phase decode
    // ------------------------------------------------------------
    logic setup;
    logic access;
    logic wr_ok;

    // setup is the first cycle of a transfer, access its last
    assign setup = psel && !penable;
    // pready_q is high only in the cycle after a setup cycle
    assign access = psel && penable && pready_q;

    // a write lands only at the access edge and only if not refused
    assign wr_ok = access && pwrite && !pslverr_q;

    // address hits
    logic hit_ctrl;
    logic hit_trm;
    logic hit_pend;
    logic hit_cnt;
    logic hit_tstat;
    logic [3:0] hit_slot;

    // exact byte compares, so unaligned addresses hit nothing
    assign hit_ctrl = paddr == rtcp_pkg::OFS_MAIN_CTRL;
    assign hit_trm = paddr == rtcp_pkg::OFS_TRIM_CFG;
    assign hit_pend = paddr == rtcp_pkg::OFS_PEND_STAT;
    assign hit_cnt = paddr == rtcp_pkg::OFS_COUNT;
    assign hit_tstat = paddr == rtcp_pkg::OFS_TRIM_STAT;
    // strobe duration registers, in status-bit order
    assign hit_slot[0] = paddr == rtcp_pkg::OFS_S1_LOW;
    assign hit_slot[1] = paddr == rtcp_pkg::OFS_S2_LOW;
    assign hit_slot[2] = paddr == rtcp_pkg::OFS_S3_LOW;
    assign hit_slot[3] = paddr == rtcp_pkg::OFS_S1_HIGH;

    logic mapped;
    logic ro_hit;
    assign mapped = hit_ctrl || hit_trm || hit_pend || hit_cnt ||
                    hit_tstat || (|hit_slot);
    // read-only registers refuse every write
    assign ro_hit = hit_pend || hit_cnt || hit_tstat;

    // ------------------------------------------------------------
    // posted duration slots
    // ------------------------------------------------------------
    // per-slot write strobes, pending flags and committed values
    logic [3:0] slot_wr;
    logic [3:0] slot_pend;
    logic [15:0] slot_val [4];
    logic slot_busy;

    // only the addressed slot sees the write strobe
    assign slot_wr = wr_ok ? hit_slot : 4'h0;
    // a slot already holding a posted write cannot take another
    assign slot_busy = |(hit_slot & slot_pend);

    // one slot per duration register, in status-bit order
    genvar gi;
    generate
        for (gi = 0; gi < rtcp_pkg::NUM_SLOTS; gi++) begin : g_slot
            rtcp_post_slot #(
                .W(rtcp_pkg::DUR_W),
                .RST(rtcp_pkg::DUR_RESET)
            ) u_slot (
                .pclk(pclk),
                .presetn(presetn),
                .wr(slot_wr[gi]),
                .wdata(pwdata[15:0]),
                .tick(tick_q),
                .pending(slot_pend[gi]),
                .value(slot_val[gi])
            );
        end
    endgenerate

    // pending flags packed into their status bit positions
    logic [15:0] pend_word;
    assign pend_word = {11'h000,
                        slot_pend[3],
                        // bit 3 has no slot in this block
                        1'b0,
                        slot_pend[2],
                        slot_pend[1],
                        slot_pend[0]};

    // ------------------------------------------------------------
    // trim interface and timer
    // ------------------------------------------------------------
    // the timer sees only the fields that it needs
    rtcp_trim_if trim_link ();

    logic cnt_en;
    logic trim_en;
    assign cnt_en = ctrl_q[rtcp_pkg::CTRL_CNT_EN];
    assign trim_en = ctrl_q[rtcp_pkg::CTRL_TRIM_EN];

    // trim runs only while both enables are set
    assign trim_link.tick = tick_q;
    assign trim_link.run = trim_en && cnt_en;
    assign trim_link.exp_min = trm_q[9:6];
    assign trim_link.interval_select = trm_q[5:4];

    // the timer owns the unit count of the running interval
    rtcp_trim_timer u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .t(trim_link.tmr)
    );

    // trim fields
    // amount and polarity applied at each trim pulse
    logic [2:0] trim_val;
    logic trim_add;
    assign trim_val = trm_q[2:0];
    assign trim_add = trm_q[rtcp_pkg::TRM_ADD];

    // ------------------------------------------------------------
    // read mux and refusal, resolved in the setup cycle
    // ------------------------------------------------------------
    // reads have no side effects, so decoding early is safe
    // the mux is flopped, so prdata never glitches in access
    always_comb begin
        prdata_d = 32'h00000000;
        if (hit_ctrl) begin
            prdata_d = {30'h00000000, ctrl_q};
        end else if (hit_trm) begin
            prdata_d = {22'h000000, trm_q};
        end else if (hit_pend) begin
            prdata_d = {16'h0000, pend_word};
        end else if (hit_cnt) begin
            prdata_d = count_q;
        end else if (hit_tstat) begin
            // applied exponent next to the running unit count
            prdata_d = {4'h0, rtcp_pkg::eff_exp(trm_q[9:6]),
                        6'h00, trim_link.units};
        end else if (hit_slot[0]) begin
            prdata_d = {16'h0000, slot_val[0]};
        end else if (hit_slot[1]) begin
            prdata_d = {16'h0000, slot_val[1]};
        end else if (hit_slot[2]) begin
            prdata_d = {16'h0000, slot_val[2]};
        end else if (hit_slot[3]) begin
            prdata_d = {16'h0000, slot_val[3]};
        end
    end

    // unmapped, read-only or busy-slot writes answer with an error
    // reads of mapped registers never fail
    assign err_d = !mapped || (pwrite && (ro_hit || slot_busy));

    // one wait-free access cycle after each setup cycle
    // a refused transfer still completes in that one access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end else begin
            pready_q <= setup;
            pslverr_q <= setup && err_d;
            prdata_q <= (setup && !pwrite) ? prdata_d : 32'h00000000;
        end
    end

    // ------------------------------------------------------------
    // control and trim configuration registers
    // ------------------------------------------------------------
    // only a clean write at the access edge changes them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= rtcp_pkg::CTRL_RESET;
            trm_q <= rtcp_pkg::TRM_RESET;
        end else if (wr_ok && hit_ctrl) begin
            ctrl_q <= pwdata[1:0];
        end else if (wr_ok && hit_trm) begin
            // stored as written; the timer clamps the exponent
            trm_q <= pwdata[9:0];
        end
    end

    // ------------------------------------------------------------
    // prescaler: one tick every PRESCALE cycles while counting
    // ------------------------------------------------------------
    // PRESCALE must be 2 or more so tick and trim pulse never meet
    // the tick is a one-cycle enable, never a derived clock
    // stopping the counter also freezes every posted write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= 16'h0000;
            tick_q <= 1'b0;
        end else if (!cnt_en) begin
            div_q <= 16'h0000;
            tick_q <= 1'b0;
        end else begin
            tick_q <= div_q == 16'(PRESCALE - 1);
            div_q <= (div_q == 16'(PRESCALE - 1)) ? 16'h0000
                     : div_q + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // rtc count with periodic trim
    // ------------------------------------------------------------
    // add jumps the count forward; subtract stalls for value ticks
    // a pulse never meets a tick, so the two branches cannot clash
    always_comb begin
        count_d = count_q;
        stall_d = stall_q;
        if (trim_link.trim_pulse) begin
            if (trim_add) begin
                count_d = count_q + {29'h00000000, trim_val};
            end else begin
                stall_d = trim_val;
            end
        end else if (tick_q) begin
            if (stall_q != 3'h0) begin
                stall_d = stall_q - 3'h1;
            end else begin
                count_d = count_q + 32'h00000001;
            end
        end
    end

    // count and stall advance together
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= 32'h00000000;
            stall_q <= 3'h0;
        end else begin
            count_q <= count_d;
            stall_q <= stall_d;
        end
    end

    // ------------------------------------------------------------
    // output registers
    // ------------------------------------------------------------
    // committed durations are copied so every output is a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dur1l_q <= rtcp_pkg::DUR_RESET;
            dur2l_q <= rtcp_pkg::DUR_RESET;
            dur3l_q <= rtcp_pkg::DUR_RESET;
            dur1h_q <= rtcp_pkg::DUR_RESET;
        end else begin
            dur1l_q <= slot_val[0];
            dur2l_q <= slot_val[1];
            dur3l_q <= slot_val[2];
            dur1h_q <= slot_val[3];
        end
    end

    // apb answer
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

    // rtc results
    assign rtc_count = count_q;
    // committed durations
    assign strobe1_low_duration = dur1l_q;
    assign strobe2_low_duration = dur2l_q;
    assign strobe3_low_duration = dur3l_q;
    assign strobe1_high_duration = dur1h_q;

endmodule : rtcp_top
`default_nettype wire

// ---- hdl/rtcp_trim_timer.sv ----
// rtcp_trim_timer: counts prescaled units and pulses at each trim
// interval end. assumes tick is a one-cycle enable from the divider.
`timescale 1ns/100ps
`default_nettype none
module rtcp_trim_timer (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // link to the register file
    rtcp_trim_if.tmr t
);
    logic [17:0] units_q;
    logic pulse_q;
    logic [4:0] shamt;
    logic [17:0] last;

    // interval is 2^(exp+ivl) units; exp is clamped first
    assign shamt = {1'b0, rtcp_pkg::eff_exp(t.exp_min)} + {3'h0, t.interval_select};
    assign last = (18'h00001 << shamt) - 18'h00001;

    // idle counter restarts whenever trimming is switched off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            units_q <= '0;
            pulse_q <= 1'b0;
        end else if (!t.run) begin
            units_q <= '0;
            pulse_q <= 1'b0;
        end else if (t.tick) begin
            pulse_q <= (units_q >= last);
            units_q <= (units_q >= last) ? 18'h00000 : units_q + 18'h00001;
        end else begin
            pulse_q <= 1'b0;
        end
    end

    assign t.trim_pulse = pulse_q;
    assign t.units = units_q;
endmodule : rtcp_trim_timer
`default_nettype wire

// ---- shared/rtcp_pkg.sv ----
// rtcp_pkg: register map, field layout, reset values and helpers
// for the rtc trim and posted-write status block.
// assumes a 32-bit apb register bus with byte addresses.
package rtcp_pkg;

    // ------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_MAIN_CTRL = 8'h00;
    localparam logic [7:0] OFS_TRIM_CFG = 8'h04;
    localparam logic [7:0] OFS_PEND_STAT = 8'h08;
    localparam logic [7:0] OFS_S1_LOW = 8'h0c;
    localparam logic [7:0] OFS_S2_LOW = 8'h10;
    localparam logic [7:0] OFS_S3_LOW = 8'h14;
    localparam logic [7:0] OFS_S1_HIGH = 8'h18;
    localparam logic [7:0] OFS_COUNT = 8'h1c;
    localparam logic [7:0] OFS_TRIM_STAT = 8'h20;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int CTRL_CNT_EN = 0;
    localparam int CTRL_TRIM_EN = 1;
    localparam int TRM_VAL_LSB = 0;
    localparam int TRM_VAL_W = 3;
    localparam int TRM_ADD = 3;
    localparam int TRM_IVL_LSB = 4;
    localparam int TRM_EXP_LSB = 6;
    localparam int TRM_W = 10;
    localparam logic [9:0] TRM_RESET = 10'h380;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam int DUR_W = 16;
    localparam logic [15:0] DUR_RESET = 16'h0000;
    localparam int NUM_SLOTS = 4;
    localparam int PEND_S1_LOW = 0;
    localparam int PEND_S2_LOW = 1;
    localparam int PEND_S3_LOW = 2;
    localparam int PEND_S1_HIGH = 4;

    // ------------------------------------------------------------
    // trim interval limits
    // ------------------------------------------------------------
    localparam logic [3:0] EXP_MIN = 4'h2;
    localparam logic [3:0] EXP_MAX = 4'he;
    localparam int UNITS_W = 18;
    localparam int PRESCALE_CYC = 100;

    // out-of-range exponents fall back to the maximum
    function automatic logic [3:0] eff_exp(input logic [3:0] e);
        eff_exp = (e < EXP_MIN || e > EXP_MAX) ? EXP_MAX : e;
    endfunction : eff_exp

endpackage : rtcp_pkg

// ---- shared/rtcp_trim_if.sv ----
// rtcp_trim_if: links the register file to the trim interval timer.
// assumes both ends sit on the same pclk.
`timescale 1ns/100ps
`default_nettype none
interface rtcp_trim_if;
    logic tick;
    logic run;
    logic [3:0] exp_min;
    logic [1:0] interval_select;
    logic trim_pulse;
    logic [17:0] units;
    modport ctl (output tick, run, exp_min, interval_select, input trim_pulse, units);
    modport tmr (input tick, run, exp_min, interval_select, output trim_pulse, units);
endinterface : rtcp_trim_if
`default_nettype wire

// ---- tb/rtcp_top_checker.sv ----
// rtcp_top_checker: port-level assertions for rtcp_top.
// assumes one pclk domain and apb3 signalling from the master.
`timescale 1ns/100ps
`default_nettype none
module rtcp_top_checker #(
    parameter int PRESCALE = 2
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // results
    input wire logic [31:0] rtc_count,
    input wire logic [15:0] strobe1_low_duration
);
    // ------------------------------------------------------------
    // shadows of what software wrote
    // ------------------------------------------------------------
    logic [1:0] ctrl_q;
    logic [9:0] trm_q;
    logic [3:0] pend_q;
    logic [3:0] same_q;
    wire acc = psel && penable && pready;
    wire wr_ok = acc && pwrite && !pslverr;
    wire is_dur = paddr >= 8'h0c && paddr <= 8'h18 && paddr[1:0] == 2'h0;
    wire [2:0] slot = paddr[4:2] - 3'h3;
    wire [3:0] e = trm_q[9:6];
    wire [3:0] eff = (e < 4'h2 || e > 4'he) ? 4'he : e;
    // pending is only tracked while the count is stopped and settled,
    // since only then can no prescale tick commit it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= 2'h0;
            trm_q <= 10'h380;
            pend_q <= 4'h0;
            same_q <= 4'h0;
        end else begin
            if (wr_ok && paddr == 8'h00) ctrl_q <= pwdata[1:0];
            if (wr_ok && paddr == 8'h04) trm_q <= pwdata[9:0];
            if (ctrl_q[0]) pend_q <= 4'h0;
            else if (wr_ok && is_dur && same_q > 4'h3)
                pend_q[slot[1:0]] <= 1'b1;
            if (wr_ok && paddr == 8'h00) same_q <= 4'h0;
            else if (same_q != 4'hf) same_q <= same_q + 4'h1;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_ready_one_cycle: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    chk_ready_only_access: assert property (pready |-> $past(psel && !penable))
        else $error("pready without setup");
    chk_err_refused: assert property (acc && (paddr > 8'h20 || paddr[1:0] != 0
        || pwrite && paddr inside {8'h08, 8'h1c, 8'h20}) |-> pslverr)
        else $error("refused access not flagged");
    chk_dur_refused: assert property (
        acc && pwrite && is_dur && pend_q[slot[1:0]] |-> pslverr)
        else $error("write to pending register accepted");
    chk_stat_pend_bits: assert property (
        acc && !pwrite && paddr == 8'h08 |->
        ({prdata[4], prdata[2:0]} & pend_q) == pend_q)
        else $error("pending flag not shown");
    chk_trim_readback: assert property (
        acc && !pwrite && paddr == 8'h04 |-> prdata == {22'h0, trm_q})
        else $error("trim register readback wrong");
    chk_exp_clamped: assert property (
        acc && !pwrite && paddr == 8'h20 |-> prdata[27:24] == eff)
        else $error("effective exponent wrong");
    chk_count_frozen: assert property (
        !ctrl_q[0] && same_q > 4'h3 |=> $stable(rtc_count)
        && $stable(strobe1_low_duration))
        else $error("count moved while stopped");
    chk_no_trim_step: assert property (
        ctrl_q == 2'h1 && same_q > 4'h3 |=>
        rtc_count - $past(rtc_count) <= 32'h1)
        else $error("count trimmed without trim enable");
    chk_idle_rdata_zero: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero outside access");
    cover property (acc && pslverr);
    cover property (acc && !pwrite && paddr == 8'h08 && pend_q != 0);
    cover property (ctrl_q == 2'h3 && rtc_count - $past(rtc_count) > 1);
endmodule : rtcp_top_checker
bind rtcp_top rtcp_top_checker #(.PRESCALE(PRESCALE)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rtc_count(rtc_count),
    .strobe1_low_duration(strobe1_low_duration));
`default_nettype wire

// ---- tb/tb.sv ----
// tb: self-checking bench for rtcp_top over apb.
// assumes one access cycle per transfer and a short prescaler.
`timescale 1ns/100ps
`default_nettype none
module tb;
    typedef struct {
        logic [31:0] d;
        logic [31:0] m;
        logic err;
    } rtcp_exp_type;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [31:0] rtc_count;
    logic [15:0] dur [4];
    logic [15:0] want [4];
    rtcp_exp_type expq[$];
    rtcp_exp_type x;
    int n_mismatch = 0;
    int checks = 0;
    int seed = 83609;
    int i;
    logic [31:0] c0;
    logic [31:0] pm;
    rtcp_top #(.PRESCALE(2)) uut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rtc_count(rtc_count),
        .strobe1_low_duration(dur[0]), .strobe2_low_duration(dur[1]),
        .strobe3_low_duration(dur[2]), .strobe1_high_duration(dur[3]));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task tally_and_finish;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : tally_and_finish
    // request held until the edge that samples pready high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [31:0] ed, input logic [31:0] em, input logic ee);
        expq.push_back('{ed, em, ee});
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // only the watchdog ends a wait that never sees pready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
        apb(1'b1, a, d, 32'h0, 32'h0, ee);
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] ed, input logic [31:0] em);
        apb(1'b0, a, 32'h0, ed, em, 1'b0);
    endtask : rd
    // steady-state count gain over 64 cycles, i.e. 32 ticks
    task run(input logic [1:0] ctl, input logic [9:0] cfg,
        input logic [31:0] exp);
        wr(8'h04, {22'h0, cfg}, 1'b0);
        wr(8'h00, {30'h0, ctl}, 1'b0);
        repeat (40) @(posedge pclk);
        #1 c0 = rtc_count;
        repeat (64) @(posedge pclk);
        #1 check(rtc_count - c0, exp);
    endtask : run
    // ------------------------------------------------------------
    // clock, watchdog and result monitor
    // ------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        tally_and_finish();
    end
    // oldest note is matched to each completed access
    always @(posedge pclk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
            x = expq.pop_front();
            check(prdata & x.m, x.d & x.m);
            check({31'h0, pslverr}, {31'h0, x.err});
        end
    end
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(8'h04, 32'h380, '1);
        rd(8'h00, 32'h0, '1);
        rd(8'h20, 32'h0e000000, 32'h0f000000);
        $display("test reset done");
        pm = 32'h0;
        for (i = 0; i < 4; i++) begin
            c0 = $random(seed);
            want[i] = c0[15:0];
            pm = pm | ((i == 3) ? 32'h10 : (32'h1 << i));
            wr(8'h0c + 8'(4 * i), c0, 1'b0);
            wr(8'h0c + 8'(4 * i), ~c0, 1'b1);
            rd(8'h08, pm, '1);
        end
        wr(8'h00, 32'h1, 1'b0);
        repeat (20) @(posedge pclk);
        rd(8'h08, 32'h0, '1);
        check({uut.strobe1_low_duration, uut.strobe2_low_duration},
            {want[0], want[1]});
        check({uut.strobe3_low_duration, uut.strobe1_high_duration},
            {want[2], want[3]});
        wr(8'h0c, 32'h1234, 1'b0);
        $display("test posted writes done");
        for (i = 0; i < 16; i++) begin
            c0 = {22'h0, 4'(i), 2'(i), 4'($random(seed))};
            wr(8'h04, c0, 1'b0);
            rd(8'h04, c0, '1);
            c0 = (i < 2 || i > 14) ? 32'he : 32'(i);
            rd(8'h20, c0 << 24, 32'h0f000000);
        end
        wr(8'h08, 32'h0, 1'b1);
        wr(8'h1c, 32'h0, 1'b1);
        wr(8'h20, 32'h0, 1'b1);
        apb(1'b0, 8'h24, 32'h0, 32'h0, 32'h0, 1'b1);
        apb(1'b0, 8'h06, 32'h0, 32'h0, 32'h0, 1'b1);
        $display("test trim fields done");
        run(2'h1, 10'b0010_00_1_011, 32'd32);
        run(2'h3, 10'b0010_00_1_011, 32'd56);
        run(2'h3, 10'b0010_01_1_011, 32'd44);
        run(2'h3, 10'b0010_00_0_001, 32'd24);
        run(2'h2, 10'b0010_00_1_011, 32'd0);
        $display("test count trim done");
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
